// ==== core/change_detect.sv ====
`timescale 1ns/1ps
module change_detect
  import gpio_cn_pkg::*;
(
  input  gpio_cn_pkg::cn_cfg_t      cfg,        // Change-notify configuration
  input  wire logic [PORT_W-1:0]    cur,        // Current synchronized levels
  input  wire logic [PORT_W-1:0]    prev,       // Levels one cycle earlier
  input  wire logic [PORT_W-1:0]    last_read,  // Levels at last pin-state read
  output logic      [PORT_W-1:0]    event_hit,  // Per-pin change event
  output logic      [PORT_W-1:0]    armed       // Pins allowed to request
);
  logic [PORT_W-1:0] rise;
  logic [PORT_W-1:0] fall;

  always_comb begin
    rise  = cur & ~prev;
    fall  = ~cur & prev;
    armed = (cfg.en_a | (cfg.en_b & {PORT_W{cfg.style}})) & cfg.dir & {PORT_W{cfg.on}};
    if (cfg.style) begin
      event_hit = (rise & cfg.en_a) | (fall & cfg.en_b);
    end else begin
      event_hit = (cur ^ last_read) & cfg.en_a;
    end
    event_hit = event_hit & armed;
  end
endmodule

// ==== core/gpio_cn_pkg.sv ====
package gpio_cn_pkg;

  localparam int          PORT_W       = 16;
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          SYNC_STAGES  = 3;

  // Base offsets; each base is followed by its clear, set and invert aliases.
  localparam logic [11:0] OFF_ANALOG   = 12'h000;
  localparam logic [11:0] OFF_DIR      = 12'h010;
  localparam logic [11:0] OFF_PINS     = 12'h020;
  localparam logic [11:0] OFF_LATCH    = 12'h030;
  localparam logic [11:0] OFF_ODRAIN   = 12'h040;
  localparam logic [11:0] OFF_EN_A     = 12'h050;
  localparam logic [11:0] OFF_STATUS   = 12'h060;
  localparam logic [11:0] OFF_EN_B     = 12'h070;
  localparam logic [11:0] OFF_FLAG     = 12'h080;
  localparam logic [11:0] OFF_CTRL     = 12'h090;

  localparam logic [1:0]  OP_BASE      = 2'h0;
  localparam logic [1:0]  OP_CLR       = 2'h1;
  localparam logic [1:0]  OP_SET       = 2'h2;
  localparam logic [1:0]  OP_INV       = 2'h3;

  localparam int          CTRL_ON_BIT    = 15;
  localparam int          CTRL_STYLE_BIT = 11;

  localparam logic [15:0] ANALOG_RST   = 16'hFFFF;
  localparam logic [15:0] DIR_RST      = 16'hFFFF;
  localparam logic [15:0] ZERO_RST     = 16'h0000;
  localparam logic [31:0] ALIAS_RDATA  = 32'h0000_0000;

  typedef struct packed {
    logic              on;
    logic              style;
    logic [PORT_W-1:0] en_a;
    logic [PORT_W-1:0] en_b;
    logic [PORT_W-1:0] dir;
  } cn_cfg_t;

endpackage

// ==== core/gpio_port_change_notify.sv ====
// Overview of operation
// - Alias writes modify only bits written one
// - Alias reads return undefined data, base shows effect
// - Direction one makes input, driver off
// - Reset sets all direction bits to input
// - Latch drives outputs; pin-state writes hit latch
// - Pin state appears three clocks after pin
// - Open-drain bit drives low or releases
// - Analog-selected pins read as zero
// - Analog select resets to all ones
// - Analog output pin still drives latched level
// - Change detection keeps working in sleep
// - Change notify runs only when on bit set
// - Per-pin enables in two enable registers
// - Edge-style bit selects transition kind
// - Style and enables encode mismatch or edges
// - Status shows change since last pin read
// - Flag set on event, software clears it
// - Only input pins raise change requests
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module gpio_port_change_notify
  import gpio_cn_pkg::*;
(
  input  wire logic                         pclk,       // System clock, 20 MHz
  input  wire logic                         presetn,    // Asynchronous reset, active low
  input  wire logic                         psel,       // APB select
  input  wire logic                         penable,    // APB enable
  input  wire logic                         pwrite,     // APB direction, high for write
  input  wire logic [gpio_cn_pkg::ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [gpio_cn_pkg::DATA_W-1:0] pwdata,   // APB write data
  output logic      [gpio_cn_pkg::DATA_W-1:0] prdata,   // APB read data
  output logic                              pready,     // APB ready
  output logic                              pslverr,    // APB error for unmapped address
  input  wire logic [gpio_cn_pkg::PORT_W-1:0] pin_in,   // Pad input levels
  output logic      [gpio_cn_pkg::PORT_W-1:0] pin_out,  // Pad output levels
  output logic      [gpio_cn_pkg::PORT_W-1:0] pin_oe_n, // Pad drive enable, low drives
  output logic      [gpio_cn_pkg::PORT_W-1:0] analog_sel, // Pad analog mode select
  output logic                              cn_irq      // Change interrupt request
);
  import gpio_cn_pkg::*;

  logic [PORT_W-1:0] analog_reg,  analog_next;
  logic [PORT_W-1:0] dir_reg,     dir_next;
  logic [PORT_W-1:0] latch_reg,   latch_next;
  logic [PORT_W-1:0] odrain_reg,  odrain_next;
  logic [PORT_W-1:0] en_a_reg,    en_a_next;
  logic [PORT_W-1:0] en_b_reg,    en_b_next;
  logic [PORT_W-1:0] status_reg,  status_next;
  logic [PORT_W-1:0] flag_reg,    flag_next;
  logic [PORT_W-1:0] prev_reg,    prev_next;
  logic [PORT_W-1:0] lastrd_reg,  lastrd_next;
  logic              on_reg,      on_next;
  logic              style_reg,   style_next;
  logic [DATA_W-1:0] prdata_reg,  prdata_next;
  logic              pready_reg,  pready_next;
  logic              pslverr_reg, pslverr_next;
  logic [PORT_W-1:0] pin_out_reg, pin_out_next;
  logic [PORT_W-1:0] oe_n_reg,    oe_n_next;
  logic [PORT_W-1:0] ansel_o_reg, ansel_o_next;
  logic              irq_reg,     irq_next;

  logic [PORT_W-1:0] pins_sync;
  logic [PORT_W-1:0] pins_val;
  logic [PORT_W-1:0] event_hit;
  logic [PORT_W-1:0] armed;
  logic [PORT_W-1:0] wval;
  logic [DATA_W-1:0] base_rd;
  cn_cfg_t           cfg;
  logic              access;
  logic              done;
  logic              wr_done;
  logic              rd_done;
  logic              mapped;
  logic [3:0]        sel;
  logic [1:0]        op;
  logic              pins_rd;
  logic              flag_wr;
  logic [PORT_W-1:0] ctrl_on_w;
  logic [PORT_W-1:0] ctrl_style_w;

  // Applies a base write or a clear, set or invert alias to one register.
  function automatic logic [PORT_W-1:0] alias_op(input logic [PORT_W-1:0] cur,
                                                 input logic [PORT_W-1:0] wd,
                                                 input logic [1:0]        kind);
    case (kind)
      OP_CLR:  alias_op = cur & ~wd;
      OP_SET:  alias_op = cur | wd;
      OP_INV:  alias_op = cur ^ wd;
      default: alias_op = wd;
    endcase
  endfunction

  // True when the register-select field addresses the word at the given offset.
  function automatic logic hit(input logic [3:0] s, input logic [11:0] off);
    hit = (s == off[7:4]);
  endfunction

  // Three synchroniser stages give the three-clock delay.
  pin_sync #(
    .WIDTH  (PORT_W),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pin_in),
    .q     (pins_sync)
  );

  // Analog pins are masked before detection as well as before the read, so a
  // pin left in analog mode raises no edge event, only a mismatch event against a high last read.
  assign pins_val = pins_sync & ~analog_reg;

  // The configuration travels to the detector as one word with a single driver.
  assign cfg = '{
    on:    on_reg,
    style: style_reg,
    en_a:  en_a_reg,
    en_b:  en_b_reg,
    dir:   dir_reg
  };

  // Detection is purely level based on the synchronised pins, so it has no
  // dependence on any power-mode signal and keeps running whenever pclk does.
  change_detect u_detect (
    .cfg       (cfg),
    .cur       (pins_val),
    .prev      (prev_reg),
    .last_read (lastrd_reg),
    .event_hit (event_hit),
    .armed     (armed)
  );

  // Bus decode: one wait state, so every answer comes from a register.
  always_comb begin
    sel     = paddr[7:4];
    op      = paddr[3:2];
    access  = psel & penable;
    done    = access & pready_reg;
    wr_done = done & pwrite;
    rd_done = done & ~pwrite;
    mapped  = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0) && (sel <= OFF_CTRL[7:4]);
    // Writes to the status word are accepted and dropped; they raise no error.
    pins_rd = rd_done & mapped & hit(sel, OFF_PINS) & (op == OP_BASE);
    flag_wr = wr_done & mapped & hit(sel, OFF_FLAG);
    wval    = pwdata[PORT_W-1:0];
    base_rd = '0;
    case (sel)
      OFF_ANALOG[7:4]: base_rd[PORT_W-1:0] = analog_reg;
      OFF_DIR[7:4]:    base_rd[PORT_W-1:0] = dir_reg;
      OFF_PINS[7:4]:   base_rd[PORT_W-1:0] = pins_val;
      OFF_LATCH[7:4]:  base_rd[PORT_W-1:0] = latch_reg;
      OFF_ODRAIN[7:4]: base_rd[PORT_W-1:0] = odrain_reg;
      OFF_EN_A[7:4]:   base_rd[PORT_W-1:0] = en_a_reg;
      OFF_STATUS[7:4]: base_rd[PORT_W-1:0] = status_reg;
      OFF_EN_B[7:4]:   base_rd[PORT_W-1:0] = en_b_reg;
      OFF_FLAG[7:4]:   base_rd[PORT_W-1:0] = flag_reg;
      OFF_CTRL[7:4]: begin
        base_rd[CTRL_ON_BIT]    = on_reg;
        base_rd[CTRL_STYLE_BIT] = style_reg;
      end
      default:         base_rd = '0;
    endcase
  end

  // Read data is captured in the first access cycle and then held, so a read of
  // the pin state shows the levels of that cycle and not of the completing one.
  always_comb begin
    pready_next  = access & ~pready_reg;
    pslverr_next = access & ~pready_reg & ~mapped;
    prdata_next  = prdata_reg;
    if (access && !pready_reg && !pwrite) begin
      if (!mapped || op != OP_BASE) begin
        prdata_next = ALIAS_RDATA;
      end else begin
        prdata_next = base_rd;
      end
    end
  end

  // Configuration registers.
  always_comb begin
    analog_next = analog_reg;
    dir_next    = dir_reg;
    latch_next  = latch_reg;
    odrain_next = odrain_reg;
    en_a_next   = en_a_reg;
    en_b_next   = en_b_reg;
    on_next     = on_reg;
    style_next  = style_reg;
    // The control word holds two loose bits, so each is widened to a full word
    // for the alias arithmetic and only its own bit position is kept.
    ctrl_on_w    = alias_op({PORT_W{on_reg}}, wval, op);
    ctrl_style_w = alias_op({PORT_W{style_reg}}, wval, op);
    if (wr_done && mapped) begin
      case (sel)
        OFF_ANALOG[7:4]: analog_next = alias_op(analog_reg, wval, op);
        OFF_DIR[7:4]:    dir_next    = alias_op(dir_reg, wval, op);
        OFF_PINS[7:4]:   latch_next  = alias_op(latch_reg, wval, op);
        OFF_LATCH[7:4]:  latch_next  = alias_op(latch_reg, wval, op);
        OFF_ODRAIN[7:4]: odrain_next = alias_op(odrain_reg, wval, op);
        OFF_EN_A[7:4]:   en_a_next   = alias_op(en_a_reg, wval, op);
        OFF_EN_B[7:4]:   en_b_next   = alias_op(en_b_reg, wval, op);
        OFF_CTRL[7:4]: begin
          on_next    = ctrl_on_w[CTRL_ON_BIT];
          style_next = ctrl_style_w[CTRL_STYLE_BIT];
        end
        default: begin
          analog_next = analog_reg;
        end
      endcase
    end
  end

  // Change tracking; a hardware set always wins over a clear in the same cycle.
  always_comb begin
    prev_next   = pins_val;
    lastrd_next = lastrd_reg;
    status_next = status_reg;
    flag_next   = flag_reg;
    if (pins_rd) begin
      lastrd_next = pins_val;
      status_next = '0;
    end
    // A base write of zero clears every flag; the clear alias clears selected ones.
    if (flag_wr) begin
      flag_next = alias_op(flag_reg, wval, op);
    end
    // Status follows every change while the port is on, whatever the enables,
    // so software can poll pins that are not allowed to interrupt.
    status_next = status_next | ((pins_val ^ prev_reg) & {PORT_W{on_reg}});
    flag_next   = flag_next | event_hit;
  end

  // Pad drive is registered from the next-state values so it tracks a write
  // on the same edge that updates the base register.
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      // Analog selection does not gate the driver, so the latched level still
      // reaches the analog peripherals on that pin.
      oe_n_next[i]    = dir_next[i] | (odrain_next[i] & latch_next[i]);
      pin_out_next[i] = latch_next[i] & ~odrain_next[i];
    end
    ansel_o_next = analog_next;
    irq_next     = |(flag_next & armed);
  end

  // All state shares one reset; the pads come up released and in analog mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_reg  <= ANALOG_RST;
      dir_reg     <= DIR_RST;
      latch_reg   <= ZERO_RST;
      odrain_reg  <= ZERO_RST;
      en_a_reg    <= ZERO_RST;
      en_b_reg    <= ZERO_RST;
      on_reg      <= 1'b0;
      style_reg   <= 1'b0;
      status_reg  <= ZERO_RST;
      flag_reg    <= ZERO_RST;
      prev_reg    <= ZERO_RST;
      lastrd_reg  <= ZERO_RST;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      pin_out_reg <= ZERO_RST;
      oe_n_reg    <= DIR_RST;
      ansel_o_reg <= ANALOG_RST;
      irq_reg     <= 1'b0;
    end else begin
      analog_reg  <= analog_next;
      dir_reg     <= dir_next;
      latch_reg   <= latch_next;
      odrain_reg  <= odrain_next;
      en_a_reg    <= en_a_next;
      en_b_reg    <= en_b_next;
      on_reg      <= on_next;
      style_reg   <= style_next;
      status_reg  <= status_next;
      flag_reg    <= flag_next;
      prev_reg    <= prev_next;
      lastrd_reg  <= lastrd_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      pin_out_reg <= pin_out_next;
      oe_n_reg    <= oe_n_next;
      ansel_o_reg <= ansel_o_next;
      irq_reg     <= irq_next;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign pin_out    = pin_out_reg;
  assign pin_oe_n   = oe_n_reg;
  assign analog_sel = ansel_o_reg;
  assign cn_irq     = irq_reg;
endmodule

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH  = 16,
  parameter int STAGES = 3
) (
  input  wire logic             clk,    // System clock
  input  wire logic             rst_n,  // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] d,      // Asynchronous pin levels
  output logic      [WIDTH-1:0] q       // Levels after STAGES edges
);
  logic [STAGES-1:0][WIDTH-1:0] stage_reg;
  logic [STAGES-1:0][WIDTH-1:0] stage_next;

  // The first stage feeds only the second; the last stage is the read value.
  always_comb begin
    stage_next = {stage_reg[STAGES-2:0], d};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign q = stage_reg[STAGES-1];
endmodule

// ==== dv/gpio_cn_properties.sv ====
`timescale 1ns/1ps
module gpio_cn_properties (
  input wire logic        pclk,       // Clock
  input wire logic        presetn,    // Reset
  input wire logic        psel,       // Select
  input wire logic        penable,    // Enable
  input wire logic        pwrite,     // Write
  input wire logic [11:0] paddr,      // Address
  input wire logic [31:0] pwdata,     // Write data
  input wire logic [31:0] prdata,     // Read data
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic [15:0] pin_in,     // Pad in
  input wire logic [15:0] pin_out,    // Pad out
  input wire logic [15:0] pin_oe_n,   // Drive enable
  input wire logic [15:0] analog_sel, // Analog mode
  input wire logic        cn_irq      // Change request
);
  default clocking dclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_done;
  logic wr_done;
  assign rd_done = psel && penable && pready && !pwrite;
  assign wr_done = psel && penable && pready && pwrite;
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (psel && penable && pready && paddr[7:4] > 4'h9 |-> pslverr)
    else $error("unmapped address accepted");
  a_rdata_hold: assert property ($changed(prdata) |-> rd_done)
    else $error("read data changed outside a read");
  a_alias_read: assert property (rd_done && paddr[3:2] != 2'h0 |-> prdata == 32'h0000_0000)
    else $error("alias read not zero");
  a_analog_zero: assert property (rd_done && paddr == 12'h020 |-> (prdata[15:0] & analog_sel) == 16'h0000)
    else $error("analog pin read as one");
  a_reset_inputs: assert property ($rose(presetn) |-> pin_oe_n == 16'hFFFF && analog_sel == 16'hFFFF)
    else $error("pins not inputs after reset");
  a_irq_clear: assert property ($fell(cn_irq) |-> $past(wr_done))
    else $error("change request dropped without a write");
  c_irq: cover property ($rose(cn_irq));
  c_err: cover property (pslverr);
  c_alias: cover property (rd_done && paddr[3:2] != 2'h0);
endmodule
bind gpio_port_change_notify gpio_cn_properties props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .analog_sel(analog_sel), .cn_irq(cn_irq)
);

// ==== dv/pad_model.sv ====
`timescale 1ns/1ps
module pad_model (
  input wire logic [15:0] pin_out,  // Design drive level
  input wire logic [15:0] pin_oe_n, // Design drive enable, low drives
  input wire logic [15:0] ext_val,  // Outside driver level
  input wire logic [15:0] ext_en,   // Pins with an outside driver
  output logic     [15:0] pin_in    // Resolved pad level
);
  // Released pins with no outside driver rise to the board pull-up, as open-drain lines need.
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
endmodule

// ==== dv/test_gpio_port_change_notify.sv ====
`timescale 1ns/1ps
module test_gpio_port_change_notify;
  import gpio_cn_pkg::*;
  typedef struct packed {logic [15:0] ctrl; logic en_a, en_b, is_in, rise, fall;} mode_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] ext_val = 16'h0000;
  logic [31:0] prdata;
  logic        pready, pslverr, cn_irq, last_err;
  logic [15:0] pin_in, pin_out, pin_oe_n, analog_sel;
  int          mismatches = 0;
  int          tests_run = 0;
  // Pin 8 under test; flags are enable A, enable B, input, rise expected, fall expected.
  mode_t       modes [8] = '{
    {16'h8800, 5'h16}, {16'h8800, 5'h0D}, {16'h8800, 5'h1F}, {16'h8800, 5'h04},
    {16'h8000, 5'h17}, {16'h8000, 5'h0C}, {16'h0800, 5'h1C}, {16'h8800, 5'h18}
  };
  gpio_port_change_notify uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .analog_sel(analog_sel), .cn_irq(cn_irq)
  );
  pad_model pads (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(16'h0100), .pin_in(pin_in)
  );
  always #25 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Each request starts one edge after the last release, so a write is never read back at once.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: no pready", $time);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask
  task automatic pulse(input logic v, input logic irq_exp, input logic on);
    logic [31:0] r;
    apb(1'b0, OFF_PINS, 32'h0000_0000, r);
    ext_val <= {7'h00, v, 8'h00};
    wr(OFF_LATCH, {23'h000000, v, 8'h00});
    repeat (6) @(negedge pclk);
    chk({31'h0, cn_irq}, {31'h0, irq_exp});
    rdc(OFF_STATUS, {23'h000000, on, 8'h00});
    apb(1'b0, OFF_PINS, 32'h0000_0000, r);
    wr(OFF_FLAG, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    chk({31'h0, cn_irq}, 32'h0000_0000);
  endtask
  task automatic final_report();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    mismatches++;
    $display("mismatch at %0t: run did not finish", $time);
    final_report();
  end
  initial begin
    logic [31:0] r;
    mode_t       m;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_ANALOG, 32'h0000_FFFF);
    rdc(OFF_DIR, 32'h0000_FFFF);
    @(negedge pclk);
    chk({16'h0000, pin_oe_n}, 32'h0000_FFFF);
    chk({16'h0000, analog_sel}, 32'h0000_FFFF);
    $display("test reset done");
    wr(OFF_PINS, 32'h0000_00F0);
    wr(OFF_LATCH + 12'h008, 32'h0000_000F);
    wr(OFF_LATCH + 12'h004, 32'h0000_0030);
    wr(OFF_LATCH + 12'h00C, 32'h0000_0101);
    rdc(OFF_LATCH, 32'h0000_01CE);
    rdc(OFF_LATCH + 12'h008, 32'h0000_0000);
    apb(1'b0, 12'h0A0, 32'h0000_0000, r);
    chk({31'h0, last_err}, 32'h0000_0001);
    $display("test registers done");
    wr(OFF_DIR + 12'h004, 32'h0000_00FF);
    wr(OFF_ODRAIN, 32'h0000_0003);
    @(negedge pclk);
    chk({16'h0000, pin_oe_n}, 32'h0000_FF02);
    chk({24'h000000, pin_out[7:0]}, 32'h0000_00CC);
    rdc(OFF_PINS, 32'h0000_0000);
    wr(OFF_ANALOG + 12'h004, 32'h0000_FFFF);
    // The pin moves in the setup cycle, too late for this read to see it.
    fork
      apb(1'b0, OFF_PINS, 32'h0000_0000, r);
      begin
        @(posedge pclk);
        ext_val <= 16'h0100;
      end
    join
    chk(r, 32'h0000_FECE);
    chk({16'h0000, analog_sel}, 32'h0000_0000);
    rdc(OFF_PINS, 32'h0000_FFCE);
    $display("test pins done");
    ext_val <= 16'h0000;
    wr(OFF_LATCH, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      m = modes[i];
      wr(OFF_DIR, {16'h0000, 7'h7F, m.is_in, 8'h00});
      wr(OFF_EN_A, {23'h000000, m.en_a, 8'h00});
      wr(OFF_EN_B, {23'h000000, m.en_b, 8'h00});
      wr(OFF_CTRL, {16'h0000, m.ctrl});
      pulse(1'b1, m.rise, m.ctrl[15]);
      pulse(1'b0, m.fall, m.ctrl[15]);
    end
    $display("test notify done");
    final_report();
  end
endmodule
